// File: hdl/crt_pkg.sv
// constants and encodings for the processor programming-model registers
package crt_pkg;

  // ==========================================================
  // register file shapes
  localparam int GEN_W     = 32;   // general integer register width
  localparam int FLT_W     = 64;   // floating-point register width
  localparam int VEC_W     = 128;  // vector register width
  localparam int REG_COUNT = 32;   // entries in each operand file
  localparam int IDX_W     = 5;    // operand register index width
  localparam int SPR_W     = 32;   // every special register width
  localparam int SEG_COUNT = 16;   // segment registers, 256 MB each
  localparam int SEG_SEL_W = 4;    // effective address bits [31:28]
  localparam int BAT_COUNT = 16;   // block translation registers
  localparam int CRF_COUNT = 8;    // condition fields
  localparam int CRF_W     = 4;    // bits per condition field

  // ==========================================================
  // machine state field positions (bit 0 is the lsb)
  localparam int MSR_SLEEP_POS = 13;  // sleep_feature_enable
  localparam int MSR_USER_POS  = 14;  // user_state_bit
  localparam int MSR_PERF_POS  = 2;   // perf_mark_bit
  localparam logic [31:0] MSR_RESET = 32'h0000_0000;  // supervisor

  // ==========================================================
  // float status/control field positions
  localparam int FS_FX_POS   = 31;  // any exception ever signalled
  localparam int FS_FEX_POS  = 30;  // enabled exception summary
  localparam int FS_EXC_LSB  = 25;  // signal bits: vx ox ux zx xx
  localparam int FS_EN_LSB   = 3;   // enables in the same order
  localparam int FS_EXC_W    = 5;
  localparam logic [31:0] FS_RESET = 32'h0000_0000;

  // ==========================================================
  // operation codes on the operand port
  localparam logic [4:0] OP_NOP    = 5'h00;
  localparam logic [4:0] OP_ADD    = 5'h01;
  localparam logic [4:0] OP_AND    = 5'h02;
  localparam logic [4:0] OP_CMP    = 5'h03;
  localparam logic [4:0] OP_LD_GEN = 5'h04;
  localparam logic [4:0] OP_ST_GEN = 5'h05;
  localparam logic [4:0] OP_LD_FLT = 5'h06;
  localparam logic [4:0] OP_ST_FLT = 5'h07;
  localparam logic [4:0] OP_LD_VEC = 5'h08;
  localparam logic [4:0] OP_ST_VEC = 5'h09;
  localparam logic [4:0] OP_MTSPR  = 5'h0A;
  localparam logic [4:0] OP_MFSPR  = 5'h0B;
  localparam logic [4:0] OP_MTMS   = 5'h0C;
  localparam logic [4:0] OP_MFMS   = 5'h0D;
  localparam logic [4:0] OP_MTSEG  = 5'h0E;
  localparam logic [4:0] OP_MFSEG  = 5'h0F;
  localparam logic [4:0] OP_MTCF   = 5'h10;
  localparam logic [4:0] OP_MFCF   = 5'h11;
  localparam logic [4:0] OP_MTFS   = 5'h12;
  localparam logic [4:0] OP_MFFS   = 5'h13;
  localparam logic [4:0] OP_FPEXC  = 5'h14;
  localparam logic [4:0] OP_MTVS   = 5'h15;
  localparam logic [4:0] OP_MFVS   = 5'h16;
  localparam logic [4:0] OP_BL     = 5'h17;
  localparam logic [4:0] OP_BCTR   = 5'h18;
  localparam logic [4:0] OP_BLR    = 5'h19;
  localparam logic [4:0] OP_BCOND  = 5'h1A;
  localparam logic [4:0] OP_EXC    = 5'h1B;
  localparam logic [4:0] OP_RFI    = 5'h1C;
  localparam logic [4:0] OP_FMOVE  = 5'h1D;

  // ==========================================================
  // special register index map (index in op_imm_in[4:0])
  localparam logic [4:0] SPR_LINK   = 5'h00;
  localparam logic [4:0] SPR_COUNT  = 5'h01;
  localparam logic [4:0] SPR_DBRK   = 5'h02;
  localparam logic [4:0] SPR_VSAVE  = 5'h03;
  localparam logic [4:0] SPR_MSSAVE = 5'h04;
  localparam logic [4:0] SPR_BAT0   = 5'h10;  // 10..17 data, 18..1F insn
  localparam logic [31:0] LINK_STEP = 32'h0000_0004;

endpackage : crt_pkg

// File: hdl/crt_regbank.sv
// flip-flop register bank with one write and two read ports
`timescale 1ns/1ps

module crt_regbank #(
  parameter int W = 32,
  parameter int D = 32,
  parameter int A = 5
) (
  // clock and reset
  input  wire logic         sys_clk_in,
  input  wire logic         reset_n_in,
  // write port
  input  wire logic         wr_en_in,
  input  wire logic [A-1:0] wr_idx_in,
  input  wire logic [W-1:0] wr_data_in,
  // read ports
  input  wire logic [A-1:0] rd_a_idx_in,
  input  wire logic [A-1:0] rd_b_idx_in,
  output logic      [W-1:0] rd_a_out,
  output logic      [W-1:0] rd_b_out
);

  logic [W-1:0] store [D];

  // ==========================================================
  // storage; cleared on reset so reads are never unknown
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < D; i++) begin
        store[i] <= '0;
      end
    end else if (wr_en_in) begin
      store[wr_idx_in] <= wr_data_in;
    end
  end

  // ==========================================================
  // reads see the old value during a write (no bypass)
  assign rd_a_out = store[rd_a_idx_in];
  assign rd_b_out = store[rd_b_idx_in];

endmodule // crt_regbank

// File: hdl/crt_regfile_top.sv
// programming-model register set of the core, driven by an operand port
// Function
// - two privilege levels: supervisor and user
// - thirty-two general integer registers as operands
// - thirty-two 64-bit float registers, single/double
// - vector file, vector status, vector save register
// - destination named apart from two sources
// - second source is register or immediate
// - only loads and stores touch memory
// - state-changing instructions need supervisor mode
// - special register access checked by user bit
// - condition register is eight 4-bit fields
// - float status holds signals, summaries, enables, rounding
// - exception saves machine state, return restores it
// - machine state has sleep feature enable bit
// - machine state has performance mark bit
// - sixteen 32-bit segments split 4 GB space
// - main and shadow segment arrays, both written
// - segment read returns the data-side copy
// - every special register is 32 bits
// - link register supplies target, captures return
// - sixteen block translation registers in pairs
// - branch-and-count decrements and tests count
// - data address breakpoint register is present
`timescale 1ns/1ps

module crt_regfile_top (
  // clock and reset
  input  wire logic         sys_clk_in,
  input  wire logic         reset_n_in,
  // operand port, one operation per valid cycle
  input  wire logic         op_valid_in,
  input  wire logic [4:0]   op_code_in,
  input  wire logic [4:0]   op_dst_in,
  input  wire logic [4:0]   op_src_a_in,
  input  wire logic [4:0]   op_src_b_in,
  input  wire logic [15:0]  op_imm_in,
  input  wire logic         op_use_imm_in,
  input  wire logic         op_rc_in,
  input  wire logic [2:0]   op_crf_in,
  input  wire logic [31:0]  op_pc_in,
  input  wire logic [31:0]  op_target_in,
  // memory load data
  input  wire logic [127:0] mem_rdata_in,
  // segment lookups
  input  wire logic [31:0]  data_ea_in,
  input  wire logic [31:0]  insn_ea_in,
  // operation results
  output logic              result_valid_out,
  output logic [127:0]      result_out,
  output logic              priv_exc_out,
  // memory requests
  output logic              mem_valid_out,
  output logic              store_out,
  output logic [31:0]       mem_addr_out,
  output logic [127:0]      store_data_out,
  // branch resolution
  output logic              branch_valid_out,
  output logic              branch_taken_out,
  output logic [31:0]       branch_target_out,
  // architectural state views
  output logic              user_mode_out,
  output logic              sleep_enable_out,
  output logic              perf_mark_out,
  output logic [31:0]       cond_fields_out,
  output logic [31:0]       float_status_out,
  output logic [31:0]       data_seg_out,
  output logic [31:0]       insn_seg_out
);

  // ==========================================================
  // state
  logic [31:0] machine_state;
  logic [31:0] state_save;
  logic [31:0] condition_result_fields;
  logic [31:0] float_status_control;
  logic [31:0] vec_status;
  logic [31:0] link_reg;
  logic [31:0] count_reg;
  logic [31:0] data_breakpoint;
  logic [31:0] vec_save;
  logic [crt_pkg::SPR_W-1:0] block_translation_regs [crt_pkg::BAT_COUNT];
  logic [31:0] seg_main   [crt_pkg::SEG_COUNT];
  logic [31:0] seg_shadow [crt_pkg::SEG_COUNT];

  // operand file read data
  logic [crt_pkg::GEN_W-1:0] gen_a, gen_b;
  logic [crt_pkg::FLT_W-1:0] flt_a, flt_b;
  logic [crt_pkg::VEC_W-1:0] vec_a, vec_b;

  // decode
  logic        is_store, sup_only, spr_sup, go;
  logic [4:0]  rd_b_idx;
  logic [31:0] simm, opnd_b, spr_rdata, next_count;
  logic        gen_we, flt_we, vec_we;
  logic [31:0] gen_wd;
  logic [63:0] flt_wd;
  logic [127:0] next_result;
  logic [4:0]  crf_lsb;
  logic [3:0]  seg_sel;
  logic [4:0]  spr_idx;
  logic [3:0]  cmp_field;
  logic [4:0]  fs_exc_new;

  assign is_store = (op_code_in == crt_pkg::OP_ST_GEN) ||
                    (op_code_in == crt_pkg::OP_ST_FLT) ||
                    (op_code_in == crt_pkg::OP_ST_VEC);
  // stores read the register named in the destination slot
  assign rd_b_idx = is_store ? op_dst_in : op_src_b_in;
  assign simm     = {{16{op_imm_in[15]}}, op_imm_in};
  assign opnd_b   = op_use_imm_in ? simm : gen_b;
  assign crf_lsb  = {op_crf_in ^ 3'h7, 2'b00};  // field 0 is the msbs
  assign seg_sel  = op_imm_in[3:0];
  assign spr_idx  = op_imm_in[4:0];
  assign next_count = count_reg - 32'h0000_0001;

  // ==========================================================
  // operand files
  crt_regbank #(.W(crt_pkg::GEN_W), .D(crt_pkg::REG_COUNT),
                .A(crt_pkg::IDX_W)) u_general_regs (
    .sys_clk_in  (sys_clk_in),
    .reset_n_in  (reset_n_in),
    .wr_en_in    (gen_we),
    .wr_idx_in   (op_dst_in),
    .wr_data_in  (gen_wd),
    .rd_a_idx_in (op_src_a_in),
    .rd_b_idx_in (rd_b_idx),
    .rd_a_out    (gen_a),
    .rd_b_out    (gen_b)
  );

  crt_regbank #(.W(crt_pkg::FLT_W), .D(crt_pkg::REG_COUNT),
                .A(crt_pkg::IDX_W)) u_float_regs (
    .sys_clk_in  (sys_clk_in),
    .reset_n_in  (reset_n_in),
    .wr_en_in    (flt_we),
    .wr_idx_in   (op_dst_in),
    .wr_data_in  (flt_wd),
    .rd_a_idx_in (op_src_a_in),
    .rd_b_idx_in (rd_b_idx),
    .rd_a_out    (flt_a),
    .rd_b_out    (flt_b)
  );

  crt_regbank #(.W(crt_pkg::VEC_W), .D(crt_pkg::REG_COUNT),
                .A(crt_pkg::IDX_W)) u_vector_regs (
    .sys_clk_in  (sys_clk_in),
    .reset_n_in  (reset_n_in),
    .wr_en_in    (vec_we),
    .wr_idx_in   (op_dst_in),
    .wr_data_in  (mem_rdata_in),
    .rd_a_idx_in (op_src_a_in),
    .rd_b_idx_in (rd_b_idx),
    .rd_a_out    (vec_a),
    .rd_b_out    (vec_b)
  );

  // ==========================================================
  // privilege check; a refused operation changes no architectural state
  always_comb begin
    sup_only = (op_code_in == crt_pkg::OP_MTMS)  ||
               (op_code_in == crt_pkg::OP_MFMS)  ||
               (op_code_in == crt_pkg::OP_MTSEG) ||
               (op_code_in == crt_pkg::OP_MFSEG) ||
               (op_code_in == crt_pkg::OP_RFI);
    spr_sup  = (spr_idx == crt_pkg::SPR_DBRK)   ||
               (spr_idx == crt_pkg::SPR_MSSAVE) ||
               (spr_idx >= crt_pkg::SPR_BAT0);
    if ((op_code_in == crt_pkg::OP_MTSPR) ||
        (op_code_in == crt_pkg::OP_MFSPR)) begin
      sup_only = spr_sup;
    end
    // user_state_bit alone selects the level
    go = op_valid_in &&
         !(machine_state[crt_pkg::MSR_USER_POS] && sup_only);
  end

  // special register read mux; unmapped indices read zero
  always_comb begin
    spr_rdata = 32'h0000_0000;
    if (spr_idx >= crt_pkg::SPR_BAT0) begin
      spr_rdata = block_translation_regs[spr_idx[3:0]];
    end else begin
      unique case (spr_idx)
        crt_pkg::SPR_LINK:   spr_rdata = link_reg;
        crt_pkg::SPR_COUNT:  spr_rdata = count_reg;
        crt_pkg::SPR_DBRK:   spr_rdata = data_breakpoint;
        crt_pkg::SPR_VSAVE:  spr_rdata = vec_save;
        crt_pkg::SPR_MSSAVE: spr_rdata = state_save;
        default:             spr_rdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // operand file write selection
  always_comb begin
    gen_we = 1'b0;
    gen_wd = 32'h0000_0000;
    flt_we = 1'b0;
    flt_wd = 64'h0000_0000_0000_0000;
    vec_we = 1'b0;
    unique case (op_code_in)
      crt_pkg::OP_ADD:    begin gen_we = go; gen_wd = gen_a + opnd_b; end
      crt_pkg::OP_AND:    begin gen_we = go; gen_wd = gen_a & opnd_b; end
      crt_pkg::OP_LD_GEN: begin gen_we = go; gen_wd = mem_rdata_in[31:0]; end
      crt_pkg::OP_MFSPR:  begin gen_we = go; gen_wd = spr_rdata; end
      crt_pkg::OP_MFMS:   begin gen_we = go; gen_wd = machine_state; end
      crt_pkg::OP_MFSEG:  begin
        gen_we = go;
        gen_wd = seg_main[seg_sel];
      end
      crt_pkg::OP_MFCF:   begin gen_we = go; gen_wd = condition_result_fields; end
      crt_pkg::OP_MFFS:   begin gen_we = go; gen_wd = float_status_control; end
      crt_pkg::OP_MFVS:   begin gen_we = go; gen_wd = vec_status; end
      crt_pkg::OP_LD_FLT: begin flt_we = go; flt_wd = mem_rdata_in[63:0]; end
      crt_pkg::OP_FMOVE:  begin flt_we = go; flt_wd = flt_a; end
      crt_pkg::OP_LD_VEC: vec_we = go;
      default:            gen_we = 1'b0;
    endcase
    next_result = {96'h0, gen_wd};
    if (flt_we) begin
      next_result = {64'h0, flt_wd};
    end else if (vec_we) begin
      next_result = mem_rdata_in;
    end
  end

  // signed compare of first source against second operand
  always_comb begin
    cmp_field = 4'h0;
    if (op_code_in == crt_pkg::OP_CMP) begin
      cmp_field = {$signed(gen_a) < $signed(opnd_b),
                   $signed(gen_a) > $signed(opnd_b),
                   gen_a == opnd_b, 1'b0};
    end else begin
      cmp_field = {$signed(gen_wd) < 0, $signed(gen_wd) > 0,
                   gen_wd == 32'h0, 1'b0};
    end
  end

  // ==========================================================
  // result and fault outputs
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      result_valid_out <= 1'b0;
      result_out       <= '0;
      priv_exc_out     <= 1'b0;
    end else begin
      result_valid_out <= gen_we || flt_we || vec_we;
      result_out       <= next_result;
      priv_exc_out     <= op_valid_in && !go;
    end
  end

  // condition fields: record forms set field 0, compares any field
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      condition_result_fields <= 32'h0000_0000;
    end else if (go) begin
      if (op_code_in == crt_pkg::OP_CMP) begin
        condition_result_fields[crf_lsb +: crt_pkg::CRF_W] <= cmp_field;
      end else if (op_rc_in && ((op_code_in == crt_pkg::OP_ADD) ||
                                (op_code_in == crt_pkg::OP_AND))) begin
        condition_result_fields[31:28] <= cmp_field;
      end else if (op_code_in == crt_pkg::OP_MTCF) begin
        condition_result_fields <= gen_a;
      end
    end
  end

  // float status: the enabled summary is recomputed by hardware on each update
  always_comb begin
    fs_exc_new = float_status_control[crt_pkg::FS_EXC_LSB +:
                                      crt_pkg::FS_EXC_W] | op_imm_in[4:0];
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      float_status_control <= crt_pkg::FS_RESET;
    end else if (go && (op_code_in == crt_pkg::OP_MTFS)) begin
      float_status_control <= gen_a;
      float_status_control[crt_pkg::FS_FEX_POS] <=
        |(gen_a[crt_pkg::FS_EXC_LSB +: crt_pkg::FS_EXC_W] &
          gen_a[crt_pkg::FS_EN_LSB +: crt_pkg::FS_EXC_W]);
    end else if (go && (op_code_in == crt_pkg::OP_FPEXC)) begin
      float_status_control[crt_pkg::FS_EXC_LSB +: crt_pkg::FS_EXC_W]
        <= fs_exc_new;
      if (|op_imm_in[4:0]) begin
        float_status_control[crt_pkg::FS_FX_POS] <= 1'b1;
      end
      float_status_control[crt_pkg::FS_FEX_POS] <= |(fs_exc_new &
        float_status_control[crt_pkg::FS_EN_LSB +: crt_pkg::FS_EXC_W]);
    end
  end

  // machine state and its exception save copy
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      machine_state <= crt_pkg::MSR_RESET;
      state_save    <= 32'h0000_0000;
    end else if (go) begin
      if (op_code_in == crt_pkg::OP_EXC) begin
        state_save <= machine_state;
        machine_state[crt_pkg::MSR_USER_POS]  <= 1'b0;
        machine_state[crt_pkg::MSR_SLEEP_POS] <= 1'b0;
      end else if (op_code_in == crt_pkg::OP_RFI) begin
        machine_state <= state_save;
      end else if (op_code_in == crt_pkg::OP_MTMS) begin
        machine_state <= gen_a;
      end else if ((op_code_in == crt_pkg::OP_MTSPR) &&
                   (spr_idx == crt_pkg::SPR_MSSAVE)) begin
        state_save <= gen_a;
      end
    end
  end

  // special registers, all 32 bits
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      link_reg        <= 32'h0000_0000;
      count_reg       <= 32'h0000_0000;
      data_breakpoint <= 32'h0000_0000;
      vec_save        <= 32'h0000_0000;
      for (int i = 0; i < crt_pkg::BAT_COUNT; i++) begin
        block_translation_regs[i] <= 32'h0000_0000;
      end
    end else if (go) begin
      if (op_code_in == crt_pkg::OP_BL) begin
        link_reg <= op_pc_in + crt_pkg::LINK_STEP;
      end else if (op_code_in == crt_pkg::OP_BCTR) begin
        count_reg <= next_count;
      end else if (op_code_in == crt_pkg::OP_MTSPR) begin
        if (spr_idx >= crt_pkg::SPR_BAT0) begin
          block_translation_regs[spr_idx[3:0]] <= gen_a;
        end else begin
          unique case (spr_idx)
            crt_pkg::SPR_LINK:  link_reg        <= gen_a;
            crt_pkg::SPR_COUNT: count_reg       <= gen_a;
            crt_pkg::SPR_DBRK:  data_breakpoint <= gen_a;
            crt_pkg::SPR_VSAVE: vec_save        <= gen_a;
            default:            vec_save        <= vec_save;
          endcase
        end
      end
    end
  end

  // vector status and control, written from a vector register, read into a general register
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      vec_status <= 32'h0000_0000;
    end else if (go && (op_code_in == crt_pkg::OP_MTVS)) begin
      vec_status <= vec_b[31:0];
    end
  end

  // segment arrays: one write fills both copies
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < crt_pkg::SEG_COUNT; i++) begin
        seg_main[i]   <= 32'h0000_0000;
        seg_shadow[i] <= 32'h0000_0000;
      end
    end else if (go && (op_code_in == crt_pkg::OP_MTSEG)) begin
      seg_main[seg_sel]   <= gen_a;
      seg_shadow[seg_sel] <= gen_a;
    end
  end

  // top four address bits pick one 256 MB segment per side
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      data_seg_out <= 32'h0000_0000;
      insn_seg_out <= 32'h0000_0000;
    end else begin
      data_seg_out <= seg_main[data_ea_in[31:28]];
      insn_seg_out <= seg_shadow[insn_ea_in[31:28]];
    end
  end

  // ==========================================================
  // memory requests, address is first source plus immediate
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mem_valid_out  <= 1'b0;
      store_out      <= 1'b0;
      mem_addr_out   <= 32'h0000_0000;
      store_data_out <= '0;
    end else begin
      mem_valid_out <= go && (is_store ||
                       (op_code_in == crt_pkg::OP_LD_GEN) ||
                       (op_code_in == crt_pkg::OP_LD_FLT) ||
                       (op_code_in == crt_pkg::OP_LD_VEC));
      store_out      <= go && is_store;
      mem_addr_out   <= gen_a + simm;
      if (op_code_in == crt_pkg::OP_ST_VEC) begin
        store_data_out <= vec_b;
      end else if (op_code_in == crt_pkg::OP_ST_FLT) begin
        store_data_out <= {64'h0, flt_b};
      end else begin
        store_data_out <= {96'h0, gen_b};
      end
    end
  end

  // branch resolution against link, count and condition bits
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      branch_valid_out  <= 1'b0;
      branch_taken_out  <= 1'b0;
      branch_target_out <= 32'h0000_0000;
    end else begin
      branch_valid_out <= go && ((op_code_in == crt_pkg::OP_BL) ||
                                 (op_code_in == crt_pkg::OP_BLR) ||
                                 (op_code_in == crt_pkg::OP_BCTR) ||
                                 (op_code_in == crt_pkg::OP_BCOND));
      branch_target_out <= (op_code_in == crt_pkg::OP_BLR) ?
                           link_reg : op_target_in;
      if (op_code_in == crt_pkg::OP_BCTR) begin
        branch_taken_out <= next_count != 32'h0000_0000;
      end else if (op_code_in == crt_pkg::OP_BCOND) begin
        branch_taken_out <= condition_result_fields[~op_src_a_in];
      end else begin
        branch_taken_out <= 1'b1;
      end
    end
  end

  // state views straight from their flip-flops
  assign user_mode_out    = machine_state[crt_pkg::MSR_USER_POS];
  assign sleep_enable_out = machine_state[crt_pkg::MSR_SLEEP_POS];
  assign perf_mark_out    = machine_state[crt_pkg::MSR_PERF_POS];
  assign cond_fields_out  = condition_result_fields;
  assign float_status_out = float_status_control;

endmodule // crt_regfile_top

// File: verification/crt_regfile_sva.sv
// concurrent checks on the register set's operand port
`timescale 1ns/1ps
module crt_regfile_sva (
  input wire logic        sys_clk_in,
  input wire logic        reset_n_in,
  input wire logic        op_valid_in,
  input wire logic [4:0]  op_code_in,
  input wire logic [31:0] op_target_in,
  input wire logic        result_valid_out,
  input wire logic        priv_exc_out,
  input wire logic        mem_valid_out,
  input wire logic        store_out,
  input wire logic        branch_valid_out,
  input wire logic [31:0] branch_target_out,
  input wire logic        user_mode_out
);
  // ==========================================================
  // one clock domain; nothing is judged while reset holds
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  a_add_result: assert property (op_valid_in &&
    op_code_in == crt_pkg::OP_ADD |=> result_valid_out) else $error("no sum");
  a_load_request: assert property (op_valid_in &&
    op_code_in == crt_pkg::OP_LD_GEN |=> mem_valid_out && !store_out)
    else $error("load request wrong");
  a_store_request: assert property (op_valid_in &&
    op_code_in == crt_pkg::OP_ST_GEN |=> mem_valid_out && store_out)
    else $error("store request wrong");
  a_mem_ldst_only: assert property (!(op_valid_in && op_code_in inside
    {[crt_pkg::OP_LD_GEN:crt_pkg::OP_ST_VEC]}) |=> !mem_valid_out)
    else $error("memory touched by non-load");
  a_user_refused: assert property (op_valid_in && user_mode_out &&
    op_code_in == crt_pkg::OP_MTMS |=> priv_exc_out && user_mode_out)
    else $error("user state write not refused");
  a_super_allowed: assert property (
    op_valid_in && !user_mode_out |=> !priv_exc_out) else $error("bad fault");
  a_exc_supervisor: assert property (op_valid_in &&
    op_code_in == crt_pkg::OP_EXC |=> !user_mode_out) else $error("exc user");
  a_link_target: assert property (op_valid_in &&
    op_code_in == crt_pkg::OP_BL |=> branch_valid_out &&
    branch_target_out == $past(op_target_in)) else $error("bad target");
  // main scenarios seen at least once
  c_refused: cover property (priv_exc_out);
  c_store: cover property (mem_valid_out && store_out);
  c_branch: cover property (branch_valid_out);
endmodule // crt_regfile_sva

// File: verification/crt_regfile_top_tb.sv
// bench for the register set: alu, segments, link, privilege
`timescale 1ns/1ps
module crt_regfile_top_tb;
  logic         sys_clk_in = 1'b0, reset_n_in = 1'b0, op_valid_in = 1'b0;
  logic         op_use_imm_in = 1'b0, sleep_enable_out, perf_mark_out;
  logic [4:0]   op_code_in = 5'h0, op_dst_in = 5'h0;
  logic [4:0]   op_src_a_in = 5'h0, op_src_b_in = 5'h0;
  logic [15:0]  op_imm_in = 16'h0;
  logic [31:0]  op_pc_in = 32'h0, op_target_in = 32'h0, ea = 32'h0;
  logic [127:0] mem_rdata_in = 128'h0, result_out, store_data_out;
  logic         result_valid_out, priv_exc_out, mem_valid_out, store_out;
  logic         branch_valid_out, user_mode_out, branch_taken_out;
  logic [31:0]  branch_target_out, cond_fields_out, data_seg_out, insn_seg_out;
  logic [31:0]  mem_addr_out;
  int           errors = 0, num_checks = 0;
  // design under test; record form always on
  crt_regfile_top crt_regfile_top_i (.sys_clk_in, .reset_n_in, .op_valid_in,
    .op_code_in, .op_dst_in, .op_src_a_in, .op_src_b_in, .op_imm_in,
    .op_use_imm_in, .op_rc_in(1'b1), .op_crf_in(3'h0), .op_pc_in,
    .op_target_in, .mem_rdata_in, .data_ea_in(ea), .insn_ea_in(ea),
    .result_valid_out, .result_out, .priv_exc_out, .mem_valid_out, .store_out,
    .mem_addr_out, .store_data_out, .branch_valid_out, .branch_taken_out,
    .branch_target_out, .user_mode_out, .sleep_enable_out, .perf_mark_out,
    .cond_fields_out, .float_status_out(), .data_seg_out, .insn_seg_out);
  always #10 sys_clk_in = ~sys_clk_in;
  task automatic chk(input string nm, input logic [127:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s: expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // one operation; a nonzero immediate is used
  task automatic op(input logic [4:0] c, d, a, b, input logic [15:0] im,
                    input logic [31:0] rd);
    @(posedge sys_clk_in);
    op_valid_in <= 1'b1;
    {op_code_in, op_dst_in, op_src_a_in, op_src_b_in} <= {c, d, a, b};
    {op_imm_in, op_use_imm_in, mem_rdata_in} <= {im, |im, 96'h0, rd};
    @(posedge sys_clk_in);
    op_valid_in <= 1'b0;
    #1;
  endtask
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_alu;
    op(crt_pkg::OP_LD_GEN, 5'h1, 5'h0, 5'h0, 16'h0, 32'h7);
    op(crt_pkg::OP_ADD, 5'h3, 5'h1, 5'h0, 16'h5, 32'h0);
    chk("sum imm", result_out, 128'hC);
    chk("field0", {124'h0, cond_fields_out[31:28]}, 128'h4);
    op(crt_pkg::OP_ADD, 5'h4, 5'h3, 5'h1, 16'h0, 32'h0);
    chk("sum reg", result_out, 128'h13);
    op(crt_pkg::OP_ST_GEN, 5'h4, 5'h1, 5'h0, 16'h0, 32'h0);
    chk("store", {store_out, store_data_out[31:0]}, 128'h1_0000_0013);
    chk("addr", mem_addr_out, 128'h7);
    $display("alu test done");
  endtask
  task automatic t_seg;
    op(crt_pkg::OP_MTSEG, 5'h0, 5'h1, 5'h0, 16'h3, 32'h0);
    @(posedge sys_clk_in);
    ea <= 32'h3000_0000;
    @(posedge sys_clk_in);
    #1;
    chk("segs", {data_seg_out, insn_seg_out}, 128'h7_0000_0007);
    op(crt_pkg::OP_MFSEG, 5'h6, 5'h0, 5'h0, 16'h3, 32'h0);
    chk("seg read", result_out, 128'h7);
    $display("segment test done");
  endtask
  task automatic t_link;
    @(posedge sys_clk_in);
    op_pc_in <= 32'h100;
    op_target_in <= 32'h200;
    op(crt_pkg::OP_BL, 5'h0, 5'h0, 5'h0, 16'h0, 32'h0);
    chk("target", branch_target_out, 128'h200);
    chk("taken", branch_taken_out, 128'h1);
    // link is special index zero
    op(crt_pkg::OP_MFSPR, 5'h7, 5'h0, 5'h0, 16'h0, 32'h0);
    chk("link", result_out, 128'h104);
    $display("link test done");
  endtask
  task automatic t_priv;
    op(crt_pkg::OP_LD_GEN, 5'h5, 5'h0, 5'h0, 16'h0, 32'h6004);
    op(crt_pkg::OP_MTMS, 5'h0, 5'h5, 5'h0, 16'h0, 32'h0);
    chk("user", {user_mode_out, sleep_enable_out}, 128'h3);
    op(crt_pkg::OP_MTMS, 5'h0, 5'h0, 5'h0, 16'h0, 32'h0);
    chk("refuse", {priv_exc_out, user_mode_out}, 128'h3);
    op(crt_pkg::OP_MTSEG, 5'h0, 5'h0, 5'h0, 16'h3, 32'h0);
    chk("seg kept", {priv_exc_out, data_seg_out}, 128'h1_0000_0007);
    op(crt_pkg::OP_EXC, 5'h0, 5'h0, 5'h0, 16'h0, 32'h0);
    chk("exc", {user_mode_out, perf_mark_out}, 128'h1);
    op(crt_pkg::OP_RFI, 5'h0, 5'h0, 5'h0, 16'h0, 32'h0);
    chk("return", user_mode_out, 128'h1);
    $display("privilege test done");
  endtask
  initial begin
    repeat (6) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    t_alu();
    t_seg();
    t_link();
    t_priv();
    finish_test();
  end
endmodule // crt_regfile_top_tb
bind crt_regfile_top crt_regfile_sva crt_regfile_sva_i (.sys_clk_in,
  .reset_n_in, .op_valid_in, .op_code_in, .op_target_in, .result_valid_out,
  .priv_exc_out, .mem_valid_out, .store_out, .branch_valid_out,
  .branch_target_out, .user_mode_out);
